// ==== core/dsc_top.v ====
// dual synthesiser control: serial register port, reference select, two channels
`timescale 1ns/1ps
`include "dsc_defs.vh"
module dsc_top (
    input  wire       SYS_CLK,
    input  wire       RESET,
    input  wire       SERIAL_CS_N,
    input  wire       SERIAL_CLK,
    input  wire       SERIAL_CMD_DATA,
    output reg        SERIAL_REPLY_DATA,
    output reg        SERIAL_REPLY_OE_N,
    output reg        IRQ_N,
    input  wire       XTAL_CLOCK_INPUT,
    input  wire       SYNTH_REF_CLOCK_INPUT,
    input  wire [1:0] VCO_FEEDBACK_POS,
    input  wire [1:0] VCO_FEEDBACK_NEG,
    output reg  [1:0] CHARGE_PUMP_UP,
    output reg  [1:0] CHARGE_PUMP_DN,
    output reg  [1:0] CHARGE_PUMP_OE_N,
    output reg  [1:0] PUMP_GAIN_HIGH
);
    localparam ST_ADDR  = 3'b001;
    localparam ST_WDATA = 3'b010;
    localparam ST_RDATA = 3'b100;

    // pin synchronisers: cs_n, sclk, data, xtal, refclk, vco1 p/n, vco2 p/n
    reg  [8:0]  pin_s1;
    reg  [8:0]  pin_s2;
    reg  [8:0]  pin_s3;
    wire [8:0]  pin_raw;
    reg  [2:0]  state;
    reg  [4:0]  bit_cnt;
    reg  [22:0] shift_in;
    reg  [7:0]  addr;
    reg  [7:0]  out_shift;
    reg  [15:0] ctrl;
    reg  [1:0]  seq;
    reg         sel_syn;
    reg         sel_set;
    reg  [`DSC_R_W-1:0] r_set [0:3];
    reg  [`DSC_N_W-1:0] n_set [0:3];
    reg  [1:0]  lost_flag;
    wire        cs_act;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        din;
    wire [15:0] wdata;
    wire        wr_commit;
    wire        rd_start;
    wire        ref_sel;
    wire        ref_tick;
    wire [1:0]  vco_tick;
    wire [1:0]  vco_now;
    wire [1:0]  vco_old;
    wire [1:0]  run;
    wire [1:0]  ch_up;
    wire [1:0]  ch_dn;
    wire [1:0]  ch_lock;
    wire [1:0]  ch_lost;
    wire [1:0]  ch_mask;
    wire [7:0]  status;

    function [7:0] chan_ctrl;
        input [15:0] c;
        input        ch;
        begin
            chan_ctrl = ch ? c[15:8] : c[7:0];
        end
    endfunction

    // raw pins only ahead of the synchronisers; decoding waits for the second stage
    assign pin_raw   = {VCO_FEEDBACK_NEG[1], VCO_FEEDBACK_POS[1],
                        VCO_FEEDBACK_NEG[0], VCO_FEEDBACK_POS[0],
                        SYNTH_REF_CLOCK_INPUT, XTAL_CLOCK_INPUT,
                        SERIAL_CMD_DATA, SERIAL_CLK, SERIAL_CS_N};
    assign cs_act    = ~pin_s2[0];
    assign sclk_rise = cs_act & pin_s2[1] & ~pin_s3[1];
    assign sclk_fall = cs_act & ~pin_s2[1] & pin_s3[1];
    assign din       = pin_s2[2];
    assign wdata     = {shift_in[14:0], din};
    assign wr_commit = (state == ST_WDATA) && sclk_rise && (bit_cnt == `DSC_WORD_LAST);
    assign rd_start  = (state == ST_ADDR) && sclk_rise && (bit_cnt == `DSC_ADDR_BITS)
                       && ({shift_in[6:0], din} == `DSC_ADDR_STAT);
    assign ref_sel   = ctrl[`DSC_C_REFSEL];
    // one reference choice feeds both channels
    assign ref_tick  = ref_sel ? (pin_s2[4] & ~pin_s3[4]) : (pin_s2[3] & ~pin_s3[3]);
    assign vco_now   = {pin_s2[7] & ~pin_s2[8], pin_s2[5] & ~pin_s2[6]};
    assign vco_old   = {pin_s3[7] & ~pin_s3[8], pin_s3[5] & ~pin_s3[6]};
    assign vco_tick  = vco_now & ~vco_old;
    assign status    = {4'h0, lost_flag, ch_lock};

    always @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            pin_s1 <= `DSC_PIN_IDLE;
            pin_s2 <= `DSC_PIN_IDLE;
            pin_s3 <= `DSC_PIN_IDLE;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // serial slave: 8 address bits, then 16 write bits or 8 read bits, msb first
    always @(posedge SYS_CLK)
    begin
        if (RESET || !cs_act)
        begin
            state             <= ST_ADDR;
            bit_cnt           <= 5'h00;
            shift_in          <= 23'h00_0000;
            addr              <= 8'h00;
            out_shift         <= 8'h00;
            SERIAL_REPLY_DATA <= 1'b0;
            SERIAL_REPLY_OE_N <= 1'b1;
        end
        else
        begin
            if (sclk_rise)
            begin
                shift_in <= {shift_in[21:0], din};
                bit_cnt  <= bit_cnt + 5'h01;
            end
            if (sclk_fall && state == ST_RDATA)
            begin
                SERIAL_REPLY_DATA <= out_shift[7];
                out_shift         <= {out_shift[6:0], 1'b0};
            end
            case (state)
                ST_ADDR:
                    if (sclk_rise && bit_cnt == `DSC_ADDR_BITS)
                    begin
                        addr <= {shift_in[6:0], din};
                        if (rd_start)
                        begin
                            state             <= ST_RDATA;
                            out_shift         <= status;
                            SERIAL_REPLY_OE_N <= 1'b0;
                        end
                        else
                            state <= ST_WDATA;
                    end
                ST_WDATA:
                    if (wr_commit)
                        state <= ST_ADDR;
                ST_RDATA:
                    state <= ST_RDATA;
                default:
                    state <= ST_ADDR;
            endcase
        end
    end

    // registers: data written in four steps straight into the target set
    always @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ctrl    <= `DSC_CTRL_RESET;
            seq     <= `DSC_SEQ_SEL;
            sel_syn <= 1'b0;
            sel_set <= 1'b0;
        end
        else if (wr_commit && addr == `DSC_ADDR_CTRL)
            ctrl <= wdata;
        else if (wr_commit && addr == `DSC_ADDR_DATA)
        begin
            seq <= seq + 2'h1;
            case (seq)
                `DSC_SEQ_SEL:
                begin
                    sel_syn <= wdata[`DSC_D_SYN];
                    sel_set <= wdata[`DSC_D_SET];
                end
                // partial values land at once, with no hold-off on the active set
                `DSC_SEQ_R:
                    r_set[{sel_syn, sel_set}] <= wdata[`DSC_R_W-1:0];
                `DSC_SEQ_NLO:
                    n_set[{sel_syn, sel_set}][15:0] <= wdata;
                `DSC_SEQ_NHI:
                    n_set[{sel_syn, sel_set}][`DSC_N_W-1:16] <= wdata[3:0];
                default:
                    seq <= `DSC_SEQ_SEL;
            endcase
        end
    end

    always @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            lost_flag        <= 2'b00;
            IRQ_N            <= 1'b1;
            CHARGE_PUMP_UP   <= 2'b00;
            CHARGE_PUMP_DN   <= 2'b00;
            CHARGE_PUMP_OE_N <= 2'b11;
            PUMP_GAIN_HIGH   <= 2'b00;
        end
        else
        begin
            // a new loss in the read cycle survives the clear
            lost_flag        <= (rd_start ? 2'b00 : lost_flag) | ch_lost;
            IRQ_N            <= ~|(lost_flag & ch_mask);
            CHARGE_PUMP_UP   <= ch_up;
            CHARGE_PUMP_DN   <= ch_dn;
            CHARGE_PUMP_OE_N <= ~(ch_up | ch_dn);
            PUMP_GAIN_HIGH   <= {ctrl[`DSC_CH_BITS + `DSC_C_GAIN], ctrl[`DSC_C_GAIN]};
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : chan
            wire [7:0] cc;
            assign cc         = chan_ctrl(ctrl, (g == 1));
            assign run[g]     = cc[`DSC_C_EN] & ~cc[`DSC_C_PSAVE];
            assign ch_mask[g] = cc[`DSC_C_MASK];
            dsc_synth_chan dsc_synth_chan_inst (
                .clk       (SYS_CLK),
                .reset     (RESET),
                .run       (run[g]),
                .ref_tick  (ref_tick),
                .vco_tick  (vco_tick[g]),
                .tol_four  (cc[`DSC_C_TOL]),
                .r_val     (r_set[{(g == 1), cc[`DSC_C_SET]}]),
                .n_val     (n_set[{(g == 1), cc[`DSC_C_SET]}]),
                .pump_up   (ch_up[g]),
                .pump_dn   (ch_dn[g]),
                .locked    (ch_lock[g]),
                .lost_lock (ch_lost[g])
            );
        end
    endgenerate
endmodule

// ==== core/dsc_defs.vh ====
// constants for the dual synthesiser control block
// Notes on behaviour
// - two channels, each with dividers, phase detector, pump and two divisor sets
// - one control write swaps a channel between its two sets, no reload
// - feedback counter is 20 bits, reference counter is 13 bits
// - one reference select, crystal or dedicated input, shared by both channels
// - reference divided by R, feedback divided by N, compared
// - phase-frequency detector drives pump up/down into a tri-state pump pin
// - per-channel lock state readable in an 8-bit read-only status register
// - locked to unlocked transition of a running channel is caught and raises the host interrupt
// - pump gain bit is control bit 3 for channel 1, bit 11 for channel 2
// - four data writes program a channel; each partial value takes effect at once
// - writes to the active set are never blocked or delayed
// - the two sets are independent; only the control register picks one
// - comparison rate set by R, from 2.5 kHz up to 200 kHz
// - lock tolerance is one or four undivided reference cycles
// - last three lock results kept; majority vote gives the lock status
// - a lock-loss event reaches the interrupt only when unmasked
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH
`define DSC_ADDR_DATA      8'hb2
`define DSC_ADDR_CTRL      8'hb3
`define DSC_ADDR_STAT      8'hb4
`define DSC_ADDR_BITS      5'h07
`define DSC_WORD_LAST      5'h17
`define DSC_N_W            20
`define DSC_R_W            13
`define DSC_CH_BITS        8
// control fields within one channel byte; REFSEL is bit 15 of the whole word
`define DSC_C_EN           0
`define DSC_C_PSAVE        1
`define DSC_C_SET          2
`define DSC_C_GAIN         3
`define DSC_C_TOL          4
`define DSC_C_MASK         5
`define DSC_C_REFSEL       15
// status fields
`define DSC_S_LOCK         0
`define DSC_S_LOST         2
// data write sequence: select, R, N low, N high
`define DSC_SEQ_SEL        2'h0
`define DSC_SEQ_R          2'h1
`define DSC_SEQ_NLO        2'h2
`define DSC_SEQ_NHI        2'h3
`define DSC_D_SYN          1
`define DSC_D_SET          0
`define DSC_TOL_ONE        3'h1
`define DSC_TOL_FOUR       3'h4
`define DSC_CTRL_RESET     16'h0000
// synchroniser idle image: select pin high, every other pin low
`define DSC_PIN_IDLE       9'h001
`endif

// ==== core/dsc_synth_chan.v ====
// one synthesiser channel: dividers, phase-frequency detector and lock detector
`timescale 1ns/1ps
`include "dsc_defs.vh"
module dsc_synth_chan (
    input  wire                   clk,
    input  wire                   reset,
    input  wire                   run,
    input  wire                   ref_tick,
    input  wire                   vco_tick,
    input  wire                   tol_four,
    input  wire [`DSC_R_W-1:0]    r_val,
    input  wire [`DSC_N_W-1:0]    n_val,
    output reg                    pump_up,
    output reg                    pump_dn,
    output reg                    locked,
    output reg                    lost_lock
);
    reg  [`DSC_R_W-1:0] r_cnt;
    reg  [`DSC_N_W-1:0] n_cnt;
    reg  [2:0]          hist;
    reg  [2:0]          err_cnt;
    wire                ref_div;
    wire                fb_div;
    wire                next_up;
    wire                next_dn;
    wire                meas_ok;
    wire [2:0]          tol;
    wire [2:0]          next_hist;
    wire                next_locked;

    function maj3;
        input [2:0] v;
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    assign ref_div     = run & ref_tick & (r_cnt <= {{(`DSC_R_W-1){1'b0}}, 1'b1});
    assign fb_div      = run & vco_tick & (n_cnt <= {{(`DSC_N_W-1){1'b0}}, 1'b1});
    assign next_up     = pump_up | ref_div;
    assign next_dn     = pump_dn | fb_div;
    assign tol         = tol_four ? `DSC_TOL_FOUR : `DSC_TOL_ONE;
    assign meas_ok     = (err_cnt <= tol);
    assign next_hist   = {hist[1:0], meas_ok};
    assign next_locked = maj3(next_hist);

    always @(posedge clk)
    begin
        lost_lock <= 1'b0;
        if (reset || !run)
        begin
            r_cnt   <= {`DSC_R_W{1'b0}};
            n_cnt   <= {`DSC_N_W{1'b0}};
            pump_up <= 1'b0;
            pump_dn <= 1'b0;
            err_cnt <= 3'h0;
            hist    <= 3'h0;
            locked  <= 1'b0;
        end
        else
        begin
            // divisors are sampled only on reload so a running cycle completes
            if (ref_tick)
                r_cnt <= (r_cnt <= {{(`DSC_R_W-1){1'b0}}, 1'b1}) ? r_val : r_cnt - 1'b1;
            if (vco_tick)
                n_cnt <= (n_cnt <= {{(`DSC_N_W-1){1'b0}}, 1'b1}) ? n_val : n_cnt - 1'b1;
            if (next_up && next_dn)
            begin
                pump_up <= 1'b0;
                pump_dn <= 1'b0;
                err_cnt <= 3'h0;
                hist    <= next_hist;
                locked  <= next_locked;
                lost_lock <= locked & ~next_locked;
            end
            else
            begin
                pump_up <= next_up;
                pump_dn <= next_dn;
                if ((next_up || next_dn) && ref_tick && err_cnt != 3'h7)
                    err_cnt <= err_cnt + 3'h1;
            end
        end
    end
endmodule

// ==== tb/dsc_checker.sv ====
// port assertions for the dual synthesiser control block
`timescale 1ns/1ps
module dsc_checker (
    input wire logic       SYS_CLK,
    input wire logic       RESET,
    input wire logic       SERIAL_CS_N,
    input wire logic       SERIAL_CLK,
    input wire logic       SERIAL_REPLY_DATA,
    input wire logic       SERIAL_REPLY_OE_N,
    input wire logic       IRQ_N,
    input wire logic [1:0] CHARGE_PUMP_UP,
    input wire logic [1:0] CHARGE_PUMP_DN,
    input wire logic [1:0] CHARGE_PUMP_OE_N,
    input wire logic [1:0] PUMP_GAIN_HIGH
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    sequence bus_quiet;
        SERIAL_CS_N [*8];
    endsequence
    sequence sclk_held;
        SERIAL_CLK [*5];
    endsequence
    reset_state_a: assert property ($fell(RESET) |-> IRQ_N && SERIAL_REPLY_OE_N
        && CHARGE_PUMP_OE_N == 2'b11 && PUMP_GAIN_HIGH == 2'b00)
        else $error("outputs not idle after reset");
    pump_drive_a: assert property (CHARGE_PUMP_OE_N == ~(CHARGE_PUMP_UP | CHARGE_PUMP_DN))
        else $error("pump enable does not follow requests");
    pump_clear0_a: assert property (!(CHARGE_PUMP_UP[0] && CHARGE_PUMP_DN[0]))
        else $error("pump 0 both held");
    pump_clear1_a: assert property (!(CHARGE_PUMP_UP[1] && CHARGE_PUMP_DN[1]))
        else $error("pump 1 both held");
    gain_hold_a: assert property (bus_quiet |=> $stable(PUMP_GAIN_HIGH))
        else $error("gain changed without a write");
    irq_hold_a: assert property (bus_quiet |=> !$rose(IRQ_N))
        else $error("interrupt released without a read");
    reply_idle_a: assert property (bus_quiet |-> SERIAL_REPLY_OE_N)
        else $error("reply driven outside a frame");
    reply_hold_a: assert property (sclk_held |-> $stable(SERIAL_REPLY_DATA))
        else $error("reply changed while serial clock high");
endmodule

// ==== tb/dsc_host_model.sv ====
// host serial master model for the control port
`timescale 1ns/1ps
module dsc_host_model (
    input  wire logic SYS_CLK,
    input  wire logic SERIAL_REPLY_DATA,
    output logic      SERIAL_CS_N = 1'b1,
    output logic      SERIAL_CLK = 1'b0,
    output logic      SERIAL_CMD_DATA = 1'b0
);
    // one serial clock phase lasts six system cycles
    task half(input logic c);
        begin
            @(negedge SYS_CLK);
            SERIAL_CLK = c;
            repeat (5) @(negedge SYS_CLK);
        end
    endtask
    task frame(input logic [7:0] a, input logic [15:0] w, input logic is_wr,
               output logic [7:0] r);
        int i;
        begin
            r = 8'h00;
            @(negedge SYS_CLK);
            SERIAL_CS_N = 1'b0;
            for (i = 0; i < (is_wr ? 24 : 8); i++)
            begin
                SERIAL_CMD_DATA = (i < 8) ? a[7 - i] : w[23 - i];
                half(1'b0);
                half(1'b1);
            end
            for (i = 0; !is_wr && i < 8; i++)
            begin
                half(1'b0);
                half(1'b1);
                r[7 - i] = SERIAL_REPLY_DATA;
            end
            half(1'b0);
            SERIAL_CS_N = 1'b1;
            SERIAL_CMD_DATA = ~SERIAL_CMD_DATA;
            repeat (8) @(negedge SYS_CLK);
        end
    endtask
endmodule

// ==== tb/test_dsc_top.sv ====
// self-checking bench for the dual synthesiser control block
`timescale 1ns/1ps
module test_dsc_top;
    logic       SYS_CLK = 1'b0;
    logic       RESET = 1'b1;
    logic       cs_n, sclk, mosi, miso, oe_n, irq_n;
    logic [1:0] up, dn, pump_oe_n, gain;
    logic [4:0] ph = 5'h00;
    logic       vco_on = 1'b1;
    logic [7:0] st;
    int         num_errors = 0;
    int         n_compared = 0;
    always #50 SYS_CLK = ~SYS_CLK;
    always @(negedge SYS_CLK) ph <= ph + 5'h01;
    dsc_top dsc_top_inst (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .SERIAL_CS_N(cs_n), .SERIAL_CLK(sclk),
        .SERIAL_CMD_DATA(mosi), .SERIAL_REPLY_DATA(miso), .SERIAL_REPLY_OE_N(oe_n),
        .IRQ_N(irq_n), .XTAL_CLOCK_INPUT(ph[4]), .SYNTH_REF_CLOCK_INPUT(ph[2]),
        .VCO_FEEDBACK_POS({ph[2], ph[2] & vco_on}), .VCO_FEEDBACK_NEG(2'b00),
        .CHARGE_PUMP_UP(up), .CHARGE_PUMP_DN(dn), .CHARGE_PUMP_OE_N(pump_oe_n),
        .PUMP_GAIN_HIGH(gain));
    dsc_host_model dsc_host_model_inst (
        .SYS_CLK(SYS_CLK), .SERIAL_REPLY_DATA(miso), .SERIAL_CS_N(cs_n),
        .SERIAL_CLK(sclk), .SERIAL_CMD_DATA(mosi));
    task summarize;
        begin
            if (num_errors == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        begin
            n_compared++;
            if (seen !== exp)
            begin
                num_errors++;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] w);
        dsc_host_model_inst.frame(a, w, 1'b1, st);
    endtask
    task rd;
        dsc_host_model_inst.frame(8'hb4, 16'h0000, 1'b0, st);
    endtask
    // channel 0 divisors: select word, R, N low, N high
    task prog(input logic s, input logic [19:0] n);
        begin
            wr(8'hb2, {15'h0000, s});
            wr(8'hb2, 16'h0004);
            wr(8'hb2, n[15:0]);
            wr(8'hb2, {12'h000, n[19:16]});
        end
    endtask
    task wait_irq(input logic v);
        int i;
        begin
            for (i = 0; i < 100 && irq_n !== v; i++) @(negedge SYS_CLK);
            chk("interrupt level", irq_n, v);
            if (irq_n !== v) summarize();
        end
    endtask
    initial
    begin
        repeat (8) @(posedge SYS_CLK);
        @(negedge SYS_CLK) RESET = 1'b0;
        repeat (4) @(negedge SYS_CLK);
        chk("interrupt after reset", irq_n, 1'b1);
        chk("pump enables after reset", pump_oe_n, 2'b11);
        prog(1'b0, 20'h0_0004);
        prog(1'b1, 20'h0_0008);
        wr(8'hb3, 16'h0808);
        chk("gain both", gain, 2'b11);
        wr(8'hb5, 16'h0000);
        chk("gain after unmapped write", gain, 2'b11);
        wr(8'hb3, 16'h8009);
        chk("gain first", gain, 2'b01);
        repeat (400) @(negedge SYS_CLK);
        rd();
        chk("status locked", st, 8'h01);
        wr(8'hb3, 16'h800d);
        repeat (600) @(negedge SYS_CLK);
        vco_on = 1'b0;
        chk("interrupt masked", irq_n, 1'b1);
        wr(8'hb3, 16'h802d);
        wait_irq(1'b0);
        rd();
        chk("status lost", st, 8'h04);
        chk("interrupt after read", irq_n, 1'b1);
        vco_on = 1'b1;
        wr(8'hb3, 16'h8020);
        wr(8'hb3, 16'h8029);
        repeat (400) @(negedge SYS_CLK);
        rd();
        chk("status relocked", st, 8'h01);
        // crystal reference is four times slower than the vco, so lock must go
        wr(8'hb3, 16'h0029);
        repeat (600) @(negedge SYS_CLK);
        wait_irq(1'b0);
        wr(8'hb3, 16'h802b);
        rd();
        chk("lock after powersave", st[0], 1'b0);
        summarize();
    end
endmodule
bind dsc_top dsc_checker dsc_checker_inst (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .SERIAL_CS_N(SERIAL_CS_N),
    .SERIAL_CLK(SERIAL_CLK), .SERIAL_REPLY_DATA(SERIAL_REPLY_DATA),
    .SERIAL_REPLY_OE_N(SERIAL_REPLY_OE_N), .IRQ_N(IRQ_N),
    .CHARGE_PUMP_UP(CHARGE_PUMP_UP), .CHARGE_PUMP_DN(CHARGE_PUMP_DN),
    .CHARGE_PUMP_OE_N(CHARGE_PUMP_OE_N), .PUMP_GAIN_HIGH(PUMP_GAIN_HIGH));
